// file: icir_regs.sv
// Module: per-context iso transmit and receive interrupt event/mask logic
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Eight tx event bits, upper bits read zero
// - Tx event set 90h, clear 94h
// - Tx mask set at 98h enables events
// - Writing one at 9Ch clears tx mask
// - Unimplemented context mask bits read zero
// - Zero bits written leave register bits alone
// - Eight rx event bits, upper bits zero
// - Rx event sets on final command interrupt-always
// - Rx event AND mask raises rx summary
// - Software set write raises rx events
// - Software clear write clears rx events
// - Read at set address returns raw events
// - Read at clear address returns masked events
// - Rx event set A0h, clear A4h
// - Rx mask set A8h, clear ACh
// - Tx event sets on last output interrupt-always
// - Tx event AND mask raises tx summary
// - No interrupt without global master enable
module icir_regs
  import icir_pkg::*;
#(
  parameter int TX_CONTEXTS = 8,
  parameter int RX_CONTEXTS = 8
)(
  input  wire logic          clk_sys,
  input  wire logic          reset,
  input  wire icir_req_type  req,
  input  wire icir_done_type tx_done,
  input  wire icir_done_type rx_done,
  input  wire logic          global_master_enable,
  input  wire logic          tx_summary_enable,
  input  wire logic          rx_summary_enable,
  output logic [31:0]        rdata,
  output logic               rvalid,
  output logic               tx_summary_flag,
  output logic               rx_summary_flag,
  output logic               irq
);

  // ---------------------------------------------------------------
  // Implemented context masks
  // ---------------------------------------------------------------
  localparam logic [8:0] TX_ONES = 9'((10'h1 << TX_CONTEXTS) - 10'h1);
  localparam logic [8:0] RX_ONES = 9'((10'h1 << RX_CONTEXTS) - 10'h1);
  localparam logic [7:0] TX_IMPL = TX_ONES[7:0];
  localparam logic [7:0] RX_IMPL = RX_ONES[7:0];

  logic [7:0] tx_context_event_reg;
  logic [7:0] tx_context_enable_reg;
  logic [7:0] rx_context_event_reg;
  logic [7:0] rx_context_enable_reg;
  logic [7:0] next_tx_event;
  logic [7:0] next_rx_event;
  logic [7:0] next_tx_enable;
  logic [7:0] next_rx_enable;
  logic [31:0] next_rdata;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire logic       hit_tx_ev_set = req.addr == TX_EVENT_SET_OFF;
  wire logic       hit_tx_ev_clr = req.addr == TX_EVENT_CLR_OFF;
  wire logic       hit_tx_mk_set = req.addr == TX_MASK_SET_OFF;
  wire logic       hit_tx_mk_clr = req.addr == TX_MASK_CLR_OFF;
  wire logic       hit_rx_ev_set = req.addr == RX_EVENT_SET_OFF;
  wire logic       hit_rx_ev_clr = req.addr == RX_EVENT_CLR_OFF;
  wire logic       hit_rx_mk_set = req.addr == RX_MASK_SET_OFF;
  wire logic       hit_rx_mk_clr = req.addr == RX_MASK_CLR_OFF;

  // Write-one strobes per register; zero bits give no strobe
  wire logic [7:0] wbits = req.wdata[7:0];
  wire logic [7:0] tx_ev_set_w =
    (req.wr && hit_tx_ev_set) ? wbits : 8'h00;
  wire logic [7:0] tx_ev_clr_w =
    (req.wr && hit_tx_ev_clr) ? wbits : 8'h00;
  wire logic [7:0] tx_mk_set_w =
    (req.wr && hit_tx_mk_set) ? wbits : 8'h00;
  wire logic [7:0] tx_mk_clr_w =
    (req.wr && hit_tx_mk_clr) ? wbits : 8'h00;
  wire logic [7:0] rx_ev_set_w =
    (req.wr && hit_rx_ev_set) ? wbits : 8'h00;
  wire logic [7:0] rx_ev_clr_w =
    (req.wr && hit_rx_ev_clr) ? wbits : 8'h00;
  wire logic [7:0] rx_mk_set_w =
    (req.wr && hit_rx_mk_set) ? wbits : 8'h00;
  wire logic [7:0] rx_mk_clr_w =
    (req.wr && hit_rx_mk_clr) ? wbits : 8'h00;

  // Hardware completion with interrupt-always control
  logic [7:0] tx_hw_set;
  logic [7:0] rx_hw_set;

  // ---------------------------------------------------------------
  // Per-context next-state logic
  // ---------------------------------------------------------------
  // Hardware set beats a software clear in the same cycle; only
  // implemented contexts can ever hold a one.
  genvar g;
  generate
    for (g = 0; g < CTX_MAX; g++)
    begin : g_ctx
      assign tx_hw_set[g] = tx_done.done[g] &&
                            tx_done.int_ctrl[g] == INT_ALWAYS;
      assign rx_hw_set[g] = rx_done.done[g] &&
                            rx_done.int_ctrl[g] == INT_ALWAYS;
      assign next_tx_event[g] = TX_IMPL[g] &&
        (tx_hw_set[g] || tx_ev_set_w[g] ||
         (tx_context_event_reg[g] && !tx_ev_clr_w[g]));
      assign next_rx_event[g] = RX_IMPL[g] &&
        (rx_hw_set[g] || rx_ev_set_w[g] ||
         (rx_context_event_reg[g] && !rx_ev_clr_w[g]));
      assign next_tx_enable[g] = TX_IMPL[g] &&
        (tx_mk_set_w[g] ||
         (tx_context_enable_reg[g] && !tx_mk_clr_w[g]));
      assign next_rx_enable[g] = RX_IMPL[g] &&
        (rx_mk_set_w[g] ||
         (rx_context_enable_reg[g] && !rx_mk_clr_w[g]));
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read selection
  // ---------------------------------------------------------------
  // Masks read back only implemented bits, which lets software probe
  wire logic [7:0] tx_masked = tx_context_event_reg & tx_context_enable_reg;
  wire logic [7:0] rx_masked = rx_context_event_reg & rx_context_enable_reg;
  wire logic [7:0] rd_low =
    hit_tx_ev_set ? tx_context_event_reg  :
    hit_tx_ev_clr ? tx_masked             :
    (hit_tx_mk_set || hit_tx_mk_clr) ? tx_context_enable_reg :
    hit_rx_ev_set ? rx_context_event_reg  :
    hit_rx_ev_clr ? rx_masked             :
    (hit_rx_mk_set || hit_rx_mk_clr) ? rx_context_enable_reg :
    8'h00;
  assign next_rdata = {RESERVED_READ, rd_low};

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Event and enable state
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      tx_context_event_reg  <= EVENT_RESET;
      rx_context_event_reg  <= EVENT_RESET;
      tx_context_enable_reg <= ENABLE_RESET;
      rx_context_enable_reg <= ENABLE_RESET;
    end
    else
    begin
      tx_context_event_reg  <= next_tx_event;
      rx_context_event_reg  <= next_rx_event;
      tx_context_enable_reg <= next_tx_enable;
      rx_context_enable_reg <= next_rx_enable;
    end
  end

  // Read answer, one cycle after the read request
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      rdata  <= 32'h00000000;
      rvalid <= 1'h0;
    end
    else
    begin
      rdata  <= req.rd ? next_rdata : 32'h00000000;
      rvalid <= req.rd;
    end
  end

  // Summary flags and the gated processor interrupt
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      tx_summary_flag <= 1'h0;
      rx_summary_flag <= 1'h0;
      irq             <= 1'h0;
    end
    else
    begin
      tx_summary_flag <= |tx_masked;
      rx_summary_flag <= |rx_masked;
      irq <= global_master_enable &&
             ((tx_summary_flag && tx_summary_enable) ||
              (rx_summary_flag && rx_summary_enable));
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence rd_rx_raw;
    req.rd && hit_rx_ev_set;
  endsequence

  sequence rd_rx_masked;
    req.rd && hit_rx_ev_clr;
  endsequence

  sequence rx_done_always;
    rx_done.done[2] && rx_done.int_ctrl[2] == INT_ALWAYS && RX_IMPL[2];
  endsequence

  tx_event_set_a: assert property (
    req.wr && hit_tx_ev_set && req.wdata[0] |=> tx_context_event_reg[0])
    else $error("tx event set write did not set bit");

  tx_event_clr_a: assert property (
    req.wr && hit_tx_ev_clr && req.wdata[7] && !tx_hw_set[7]
    |=> !tx_context_event_reg[7])
    else $error("tx event clear write did not clear bit");

  tx_mask_set_a: assert property (
    req.wr && hit_tx_mk_set && req.wdata[7] && TX_IMPL[7]
    |=> tx_context_enable_reg[7])
    else $error("tx mask set write did not set bit");

  tx_mask_clr_a: assert property (
    req.wr && hit_tx_mk_clr && req.wdata[7] |=> !tx_context_enable_reg[7])
    else $error("tx mask clear write did not clear bit");

  mask_unimpl_a: assert property (
    ((tx_context_enable_reg & ~TX_IMPL) == 8'h00) &&
    ((rx_context_enable_reg & ~RX_IMPL) == 8'h00))
    else $error("unimplemented mask bit holds a one");

  zero_write_keep_a: assert property (
    req.wr && hit_rx_mk_clr && !req.wdata[2]
    |=> rx_context_enable_reg[2] == $past(rx_context_enable_reg[2]))
    else $error("zero bit in clear write changed mask");

  rx_hw_event_a: assert property (
    rx_done_always |=> rx_context_event_reg[2] ##1
      (rx_context_event_reg[2] ||
       $past(req.wr && hit_rx_ev_clr && req.wdata[2])))
    else $error("rx completion did not latch event");

  tx_hw_event_a: assert property (
    tx_done.done[7] && tx_done.int_ctrl[7] == INT_ALWAYS && TX_IMPL[7]
    |=> tx_context_event_reg[7])
    else $error("tx completion did not latch event");

  rx_summary_a: assert property (
    (|(rx_context_event_reg & rx_context_enable_reg)) |=> rx_summary_flag)
    else $error("rx summary not raised");

  tx_summary_a: assert property (
    !(|(tx_context_event_reg & tx_context_enable_reg)) |=> !tx_summary_flag)
    else $error("tx summary raised without cause");

  rx_raw_read_a: assert property (
    rd_rx_raw |=> rvalid && rdata[7:0] == $past(rx_context_event_reg))
    else $error("raw rx read returned wrong value");

  rx_masked_read_a: assert property (
    rd_rx_masked |=> rvalid &&
      rdata[7:0] == $past(rx_context_event_reg & rx_context_enable_reg))
    else $error("masked rx read returned wrong value");

  reserved_zero_a: assert property (
    rdata[31:8] == RESERVED_READ)
    else $error("reserved read bits not zero");

  irq_master_a: assert property (
    irq |-> $past(global_master_enable))
    else $error("interrupt without master enable");

  rx_event_set_a: assert property (
    req.wr && hit_rx_ev_set && req.wdata[0] |=> rx_context_event_reg[0])
    else $error("rx event set write did not set bit");

  rx_event_clr_a: assert property (
    req.wr && hit_rx_ev_clr && req.wdata[4] && !rx_hw_set[4]
    |=> !rx_context_event_reg[4])
    else $error("rx event clear write did not clear bit");

  rx_mask_set_a: assert property (
    req.wr && hit_rx_mk_set && req.wdata[0] && RX_IMPL[0]
    |=> rx_context_enable_reg[0])
    else $error("rx mask set write did not set bit");

  read_idle_a: assert property (
    !req.rd |=> !rvalid && rdata == 32'h00000000)
    else $error("read answer without a read request");

  irq_follow_a: assert property (
    global_master_enable && rx_summary_flag && rx_summary_enable |=> irq)
    else $error("enabled rx summary gave no interrupt");

endmodule : icir_regs

`default_nettype wire

// file: icir_pkg.sv
// Package: register map, carriers and constants of the iso interrupt block
`default_nettype none

package icir_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses inside the host window)
  // ---------------------------------------------------------------
  localparam int          ADDR_W            = 8;
  localparam logic [7:0]  TX_EVENT_SET_OFF  = 8'h90;
  localparam logic [7:0]  TX_EVENT_CLR_OFF  = 8'h94;
  localparam logic [7:0]  TX_MASK_SET_OFF   = 8'h98;
  localparam logic [7:0]  TX_MASK_CLR_OFF   = 8'h9c;
  localparam logic [7:0]  RX_EVENT_SET_OFF  = 8'ha0;
  localparam logic [7:0]  RX_EVENT_CLR_OFF  = 8'ha4;
  localparam logic [7:0]  RX_MASK_SET_OFF   = 8'ha8;
  localparam logic [7:0]  RX_MASK_CLR_OFF   = 8'hac;

  // ---------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------
  localparam int          CTX_MAX           = 8;
  localparam logic [7:0]  EVENT_RESET       = 8'h00;
  localparam logic [7:0]  ENABLE_RESET      = 8'h00;
  localparam logic [23:0] RESERVED_READ     = 24'h000000;
  localparam logic [1:0]  INT_ALWAYS        = 2'h3;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } icir_req_type;

  typedef struct packed {
    logic [CTX_MAX-1:0]      done;
    logic [CTX_MAX-1:0][1:0] int_ctrl;
  } icir_done_type;

endpackage : icir_pkg

`default_nettype wire

// file: icir_regs_tb.sv
// Testbench: self-checking scenarios for the iso interrupt register block
`timescale 1ns/1ps
`default_nettype none

module testbench
  import icir_pkg::*;
;
  // -------------------------------------------------------------
  // Signals and counters
  // -------------------------------------------------------------
  logic          clk_sys;
  logic          reset;
  icir_req_type  req;
  icir_done_type tx_done;
  icir_done_type rx_done;
  logic          master_en;
  logic          tx_en;
  logic          rx_en;
  logic [31:0]   rdata;
  logic          rvalid;
  logic          tx_flag;
  logic          rx_flag;
  logic          irq;
  int            n_errors;
  int            check_count;

  // Receive side has six contexts so unimplemented bits can be probed
  icir_regs #(.TX_CONTEXTS(8), .RX_CONTEXTS(6)) u_icir_regs (
    .clk_sys              (clk_sys),
    .reset                (reset),
    .req                  (req),
    .tx_done              (tx_done),
    .rx_done              (rx_done),
    .global_master_enable (master_en),
    .tx_summary_enable    (tx_en),
    .rx_summary_enable    (rx_en),
    .rdata                (rdata),
    .rvalid               (rvalid),
    .tx_summary_flag      (tx_flag),
    .rx_summary_flag      (rx_flag),
    .irq                  (irq)
  );

  // -------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req.wr    <= 1'h1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge clk_sys);
    req.wr    <= 1'h0;
  endtask : wr

  // Reads one word and compares it, rvalid included
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    req.rd   <= 1'h1;
    req.addr <= a;
    @(posedge clk_sys);
    req.rd   <= 1'h0;
    #1;
    check({31'h0, rvalid}, 32'h1);
    check(rdata, exp);
    @(posedge clk_sys);
    #1;
    check({31'h0, rvalid}, 32'h0);
    check(rdata, 32'h0);
  endtask : rd_chk

  // One completion pulse on a transmit or receive context
  task automatic pulse(input bit is_tx, input int i, input logic [1:0] c);
    @(posedge clk_sys);
    if (is_tx)
    begin
      tx_done.done[i]     <= 1'h1;
      tx_done.int_ctrl[i] <= c;
    end
    else
    begin
      rx_done.done[i]     <= 1'h1;
      rx_done.int_ctrl[i] <= c;
    end
    @(posedge clk_sys);
    tx_done <= '0;
    rx_done <= '0;
  endtask : pulse

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_reset_values();
    rd_chk(TX_EVENT_SET_OFF, 32'h0);
    rd_chk(TX_MASK_CLR_OFF, 32'h0);
    rd_chk(RX_EVENT_CLR_OFF, 32'h0);
    rd_chk(RX_MASK_SET_OFF, 32'h0);
    rd_chk(8'h80, 32'h0);
    wr(8'h80, 32'hffffffff);
    rd_chk(TX_MASK_SET_OFF, 32'h0);
    $display("test reset_values done");
  endtask : t_reset_values

  task automatic t_mask_probe();
    wr(TX_MASK_SET_OFF, 32'hffffffff);
    rd_chk(TX_MASK_SET_OFF, 32'h000000ff);
    wr(TX_MASK_CLR_OFF, 32'h0000000f);
    rd_chk(TX_MASK_CLR_OFF, 32'h000000f0);
    wr(RX_MASK_SET_OFF, 32'hffffffff);
    rd_chk(RX_MASK_SET_OFF, 32'h0000003f);
    wr(RX_MASK_CLR_OFF, 32'h00000030);
    rd_chk(RX_MASK_CLR_OFF, 32'h0000000f);
    $display("test mask_probe done");
  endtask : t_mask_probe

  task automatic t_soft_events();
    wr(TX_EVENT_SET_OFF, 32'h00000081);
    repeat (2) @(posedge clk_sys);
    #1;
    check({31'h0, tx_flag}, 32'h1);
    rd_chk(TX_EVENT_SET_OFF, 32'h00000081);
    rd_chk(TX_EVENT_CLR_OFF, 32'h00000080);
    wr(TX_EVENT_CLR_OFF, 32'h00000080);
    rd_chk(TX_EVENT_SET_OFF, 32'h00000001);
    check({31'h0, tx_flag}, 32'h0);
    wr(RX_EVENT_SET_OFF, 32'h000000ff);
    rd_chk(RX_EVENT_SET_OFF, 32'h0000003f);
    rd_chk(RX_EVENT_CLR_OFF, 32'h0000000f);
    check({31'h0, rx_flag}, 32'h1);
    wr(RX_EVENT_CLR_OFF, 32'h0000000f);
    rd_chk(RX_EVENT_SET_OFF, 32'h00000030);
    check({31'h0, rx_flag}, 32'h0);
    wr(RX_EVENT_CLR_OFF, 32'h000000ff);
    rd_chk(RX_EVENT_SET_OFF, 32'h00000000);
    $display("test soft_events done");
  endtask : t_soft_events

  task automatic t_hw_events();
    pulse(1'h0, 2, 2'h1);
    rd_chk(RX_EVENT_SET_OFF, 32'h00000000);
    pulse(1'h0, 2, INT_ALWAYS);
    rd_chk(RX_EVENT_SET_OFF, 32'h00000004);
    @(posedge clk_sys);
    master_en <= 1'h1;
    rx_en     <= 1'h1;
    wr(RX_EVENT_SET_OFF, 32'h00000000);
    #1;
    check({31'h0, rx_flag}, 32'h1);
    check({31'h0, irq}, 32'h1);
    rd_chk(RX_EVENT_SET_OFF, 32'h00000004);
    @(posedge clk_sys);
    master_en <= 1'h0;
    repeat (2) @(posedge clk_sys);
    #1;
    check({31'h0, irq}, 32'h0);
    pulse(1'h1, 7, INT_ALWAYS);
    rd_chk(TX_EVENT_SET_OFF, 32'h00000081);
    @(posedge clk_sys);
    master_en <= 1'h1;
    tx_en     <= 1'h1;
    rx_en     <= 1'h0;
    wr(RX_MASK_CLR_OFF, 32'h000000ff);
    repeat (2) @(posedge clk_sys);
    #1;
    check({30'h0, tx_flag, irq}, 32'h3);
    check({31'h0, rx_flag}, 32'h0);
    wr(TX_MASK_CLR_OFF, 32'h000000ff);
    repeat (2) @(posedge clk_sys);
    #1;
    check({31'h0, irq}, 32'h0);
    $display("test hw_events done");
  endtask : t_hw_events

  // -------------------------------------------------------------
  // Clock, watchdog and main sequence
  // -------------------------------------------------------------
  initial
  begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Whole run is about 126 cycles; cut off well beyond that
  initial
  begin
    #400000;
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    n_errors    = 0;
    check_count = 0;
    reset       = 1'h1;
    req         = '0;
    tx_done     = '0;
    rx_done     = '0;
    master_en   = 1'h0;
    tx_en       = 1'h0;
    rx_en       = 1'h0;
    repeat (20) @(posedge clk_sys);
    reset <= 1'h0;
    t_reset_values();
    t_mask_probe();
    t_soft_events();
    t_hw_events();
    report_and_stop();
  end
endmodule : testbench

`default_nettype wire
